// >>> core/dmr_redirect.sv
// distributed dma register redirect: retries processor cycles and forwards them to relocated channel registers
`timescale 1ns/10ps
`include "dmr_regs.svh"

module dmr_redirect
	import dmr_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// configuration
	input wire logic [7:0] dist_chan_en,
	input wire logic [15:0] ptr_low_group,
	input wire logic [15:0] ptr_high_group,
	input wire logic alt_access,
	// processor side target cycles
	input wire logic tgt_req,
	input wire logic tgt_write,
	input wire logic [15:0] tgt_addr,
	input wire logic [15:0] tgt_wdata,
	output logic tgt_done,
	output logic tgt_retry,
	output logic [15:0] tgt_rdata,
	// forwarded bus master cycles
	output logic bus_req,
	input wire logic bus_gnt,
	output logic fwd_valid,
	output logic fwd_write,
	output logic [15:0] fwd_addr,
	output logic [15:0] fwd_wdata,
	output logic [3:0] fwd_byte_en_n,
	input wire logic fwd_done,
	input wire logic [15:0] fwd_rdata,
	// internal controller access
	output logic ctl_req,
	output logic ctl_write,
	output logic [15:0] ctl_addr,
	output logic [15:0] ctl_wdata,
	input wire logic ctl_done,
	input wire logic [15:0] ctl_rdata
);

////////////////////////////////////////////////////////////////////////////////

	dmr_regs_t s;
	dmr_regs_t next_s;
	dmr_dec_t dec;
	logic redirect;
	logic [2:0] grp_tmp;
	logic [1:0] grp_idx;
	logic [3:0] reg_idx;
	logic [15:0] ptr_sel;
	logic pending_match;

	function automatic dmr_dec_t decode(input logic [15:0] a);
		dmr_dec_t d;
		d.hit = 1'b1;
		d.ch = 3'h0;
		d.kind = DMR_KIND_NONE;
		unique case (a)
			`DMR_CH0_ADDRESS: begin
				d.ch = 3'h0;
				d.kind = DMR_KIND_ADDRESS;
			end
			`DMR_CH1_ADDRESS: begin
				d.ch = 3'h1;
				d.kind = DMR_KIND_ADDRESS;
			end
			`DMR_CH2_ADDRESS: begin
				d.ch = 3'h2;
				d.kind = DMR_KIND_ADDRESS;
			end
			`DMR_CH3_ADDRESS: begin
				d.ch = 3'h3;
				d.kind = DMR_KIND_ADDRESS;
			end
			`DMR_CH5_ADDRESS: begin
				d.ch = 3'h5;
				d.kind = DMR_KIND_ADDRESS;
			end
			`DMR_CH6_ADDRESS: begin
				d.ch = 3'h6;
				d.kind = DMR_KIND_ADDRESS;
			end
			`DMR_CH7_ADDRESS: begin
				d.ch = 3'h7;
				d.kind = DMR_KIND_ADDRESS;
			end
			`DMR_CH0_WORD_COUNT: begin
				d.ch = 3'h0;
				d.kind = DMR_KIND_COUNT;
			end
			`DMR_CH1_WORD_COUNT: begin
				d.ch = 3'h1;
				d.kind = DMR_KIND_COUNT;
			end
			`DMR_CH2_WORD_COUNT: begin
				d.ch = 3'h2;
				d.kind = DMR_KIND_COUNT;
			end
			`DMR_CH3_WORD_COUNT: begin
				d.ch = 3'h3;
				d.kind = DMR_KIND_COUNT;
			end
			`DMR_CH5_WORD_COUNT: begin
				d.ch = 3'h5;
				d.kind = DMR_KIND_COUNT;
			end
			`DMR_CH6_WORD_COUNT: begin
				d.ch = 3'h6;
				d.kind = DMR_KIND_COUNT;
			end
			`DMR_CH7_WORD_COUNT: begin
				d.ch = 3'h7;
				d.kind = DMR_KIND_COUNT;
			end
			`DMR_CH0_PAGE: begin
				d.ch = 3'h0;
				d.kind = DMR_KIND_PAGE;
			end
			`DMR_CH1_PAGE: begin
				d.ch = 3'h1;
				d.kind = DMR_KIND_PAGE;
			end
			`DMR_CH2_PAGE: begin
				d.ch = 3'h2;
				d.kind = DMR_KIND_PAGE;
			end
			`DMR_CH3_PAGE: begin
				d.ch = 3'h3;
				d.kind = DMR_KIND_PAGE;
			end
			`DMR_CH5_PAGE: begin
				d.ch = 3'h5;
				d.kind = DMR_KIND_PAGE;
			end
			`DMR_CH6_PAGE: begin
				d.ch = 3'h6;
				d.kind = DMR_KIND_PAGE;
			end
			`DMR_CH7_PAGE: begin
				d.ch = 3'h7;
				d.kind = DMR_KIND_PAGE;
			end
			default: begin
				d.hit = 1'b0;
			end
		endcase
		return d;
	endfunction

////////////////////////////////////////////////////////////////////////////////
// decode and relocated address

	assign dec = decode(tgt_addr);

	// channel 4 has no slot in either group, so it never redirects
	assign redirect = dec.hit && dist_chan_en[dec.ch] && (dec.ch != `DMR_CH_INTERNAL)
		&& !alt_access;

	assign grp_tmp = dec.ch - `DMR_CH_HIGH_FIRST;
	assign grp_idx = dec.ch[2] ? grp_tmp[1:0] : dec.ch[1:0];
	assign ptr_sel = dec.ch[2] ? ptr_high_group : ptr_low_group;

	always_comb begin
		unique case (dec.kind)
			DMR_KIND_COUNT: reg_idx = `DMR_IDX_WORD_COUNT;
			DMR_KIND_PAGE: reg_idx = `DMR_IDX_PAGE;
			default: reg_idx = `DMR_IDX_ADDRESS;
		endcase
	end

	assign pending_match = (tgt_addr == s.addr) && (tgt_write == s.write);

////////////////////////////////////////////////////////////////////////////////
// sequencer

	always_comb begin
		next_s = s;
		next_s.tgt_done = 1'b0;
		next_s.tgt_retry = 1'b0;
		unique case (s.state)
			DMR_IDLE: begin
				if (tgt_req) begin
					next_s.addr = tgt_addr;
					next_s.write = tgt_write;
					next_s.wdata = tgt_wdata;
					next_s.ch = dec.ch;
					next_s.kind = dec.kind;
					// low six bits of the pointer are ignored, which forces block alignment
					next_s.fwd_addr = {ptr_sel[15:6], grp_idx, reg_idx};
					if (redirect) begin
						next_s.tgt_retry = 1'b1;
						next_s.bus_req = 1'b1;
						next_s.state = DMR_ARB;
					end else begin
						// state-save accesses land here, so base registers read back only then
						next_s.ctl_req = 1'b1;
						next_s.state = DMR_LOCAL;
					end
				end
			end
			DMR_LOCAL: begin
				if (ctl_done) begin
					next_s.ctl_req = 1'b0;
					next_s.tgt_done = 1'b1;
					next_s.tgt_rdata = ctl_rdata;
					next_s.state = DMR_IDLE;
				end
			end
			DMR_ARB: begin
				next_s.tgt_retry = tgt_req;
				if (bus_gnt) begin
					next_s.bus_req = 1'b0;
					next_s.fwd_valid = 1'b1;
					next_s.state = DMR_FWD;
				end
			end
			DMR_FWD: begin
				next_s.tgt_retry = tgt_req;
				if (fwd_done) begin
					next_s.fwd_valid = 1'b0;
					next_s.periph = fwd_rdata;
					next_s.result = fwd_rdata;
					// only the page needs the internal copy; address and count come whole from the peripheral
					if (s.kind == DMR_KIND_PAGE) begin
						next_s.ctl_req = 1'b1;
						next_s.state = DMR_CTL;
					end else begin
						next_s.state = DMR_READY;
					end
				end
			end
			DMR_CTL: begin
				next_s.tgt_retry = tgt_req;
				if (ctl_done) begin
					next_s.ctl_req = 1'b0;
					next_s.result = {ctl_rdata[15:8], s.periph[7:0]};
					next_s.state = DMR_READY;
				end
			end
			DMR_READY: begin
				if (tgt_req) begin
					if (pending_match) begin
						next_s.tgt_done = 1'b1;
						next_s.tgt_rdata = s.result;
						next_s.state = DMR_IDLE;
					end else begin
						// a foreign cycle must not steal the held result
						next_s.tgt_retry = 1'b1;
					end
				end
			end
			default: begin
				next_s.state = DMR_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// outputs

	assign tgt_done = s.tgt_done;
	assign tgt_retry = s.tgt_retry;
	assign tgt_rdata = s.tgt_rdata;
	assign bus_req = s.bus_req;
	assign fwd_valid = s.fwd_valid;
	assign fwd_write = s.write;
	assign fwd_addr = s.fwd_addr;
	assign fwd_wdata = s.wdata;
	assign fwd_byte_en_n = `DMR_BE_WORD_N;
	assign ctl_req = s.ctl_req;
	assign ctl_write = s.write;
	assign ctl_addr = s.addr;
	assign ctl_wdata = s.wdata;

////////////////////////////////////////////////////////////////////////////////
// checks

	AST_RETRY_ON_REDIRECT: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(s.state == DMR_IDLE) && tgt_req && redirect |=> tgt_retry && !tgt_done && bus_req)
		else $error("redirected access was not retried");

	AST_CH4_LOCAL: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(s.state == DMR_IDLE) && tgt_req && !redirect |=> !tgt_retry && ctl_req && !bus_req)
		else $error("local access was redirected");

	AST_ALT_LOCAL: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(s.state == DMR_IDLE) && tgt_req && alt_access |=> (s.state == DMR_LOCAL) && !bus_req)
		else $error("state-save access used redirection");

	AST_BASE_PTR: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(s.state == DMR_IDLE) && tgt_req && redirect && !dec.ch[2]
		|=> fwd_addr[15:6] == $past(ptr_low_group[15:6]) && fwd_addr[5:4] == $past(dec.ch[1:0]))
		else $error("low group forwarded address wrong");

	AST_SPACING: assert property (@(posedge ref_clk) disable iff (!reset_n)
		fwd_valid && s.ch[2] |-> fwd_addr[5:4] == (s.ch[1:0] - 2'h1) && fwd_addr[15:6] == ptr_high_group[15:6])
		else $error("high group channel spacing wrong");

	AST_REG_INDEX: assert property (@(posedge ref_clk) disable iff (!reset_n)
		fwd_valid && (s.kind == DMR_KIND_PAGE) |-> fwd_addr[3:0] == 4'h4)
		else $error("page register index wrong");

	AST_GRANT_TO_CYCLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(s.state == DMR_ARB) && bus_gnt |=> fwd_valid && !bus_req ##0 fwd_valid [*1])
		else $error("no forwarded cycle after grant");

	AST_WORD_CYCLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		fwd_valid && fwd_done |=> !fwd_valid && fwd_byte_en_n == 4'hc && (s.state != DMR_FWD))
		else $error("forwarded cycle not single 16-bit");

	AST_WRITE_DATA: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(s.state == DMR_IDLE) && tgt_req && redirect && tgt_write
		|=> fwd_wdata == $past(tgt_wdata) && fwd_write)
		else $error("forwarded write data differs from original");

	AST_PAGE_MERGE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(s.state == DMR_CTL) && ctl_done |=> s.result == {$past(ctl_rdata[15:8]), s.periph[7:0]})
		else $error("page read merge wrong");

	AST_COMPLETE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(s.state == DMR_READY) && tgt_req && pending_match |=> tgt_done && tgt_rdata == $past(s.result))
		else $error("reissued cycle not completed with result");

	AST_KEEP_RETRY: assert property (@(posedge ref_clk) disable iff (!reset_n)
		tgt_req && ((s.state == DMR_ARB) || (s.state == DMR_FWD) || (s.state == DMR_CTL)) |=> tgt_retry && !tgt_done)
		else $error("pending redirect did not retry");

	AST_SINGLE_FORWARD: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(s.state == DMR_FWD) && fwd_done && (s.kind != DMR_KIND_PAGE)
		|=> (s.state == DMR_READY) && !ctl_req && !fwd_valid)
		else $error("address or count access used more than one cycle");

	AST_FOREIGN_RETRY: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(s.state == DMR_READY) && tgt_req && !pending_match |=> tgt_retry && !tgt_done && (s.state == DMR_READY))
		else $error("foreign cycle took the held result");

	AST_LOCAL_DONE: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(s.state == DMR_LOCAL) && ctl_done |=> tgt_done && !tgt_retry && !ctl_req && tgt_rdata == $past(ctl_rdata))
		else $error("local access did not complete with controller data");

endmodule

// >>> shared/dmr_regs.svh
// register offsets, relocation layout and cycle format constants for the redirect block
`ifndef DMR_REGS_SVH
`define DMR_REGS_SVH

// channel address registers (write hits base, read hits current)
`define DMR_CH0_ADDRESS 16'h0000
`define DMR_CH1_ADDRESS 16'h0002
`define DMR_CH2_ADDRESS 16'h0004
`define DMR_CH3_ADDRESS 16'h0006
`define DMR_CH5_ADDRESS 16'h00c4
`define DMR_CH6_ADDRESS 16'h00c8
`define DMR_CH7_ADDRESS 16'h00cc

// channel word count registers
`define DMR_CH0_WORD_COUNT 16'h0001
`define DMR_CH1_WORD_COUNT 16'h0003
`define DMR_CH2_WORD_COUNT 16'h0005
`define DMR_CH3_WORD_COUNT 16'h0007
`define DMR_CH5_WORD_COUNT 16'h00c6
`define DMR_CH6_WORD_COUNT 16'h00ca
`define DMR_CH7_WORD_COUNT 16'h00ce

// page registers
`define DMR_CH0_PAGE 16'h0087
`define DMR_CH1_PAGE 16'h0083
`define DMR_CH2_PAGE 16'h0081
`define DMR_CH3_PAGE 16'h0082
`define DMR_CH5_PAGE 16'h008b
`define DMR_CH6_PAGE 16'h0089
`define DMR_CH7_PAGE 16'h008a

// register index inside a relocated 16-byte channel block
`define DMR_IDX_ADDRESS 4'h0
`define DMR_IDX_WORD_COUNT 4'h2
`define DMR_IDX_PAGE 4'h4

// channel that always stays in the internal controller
`define DMR_CH_INTERNAL 3'h4
// first channel of the upper group
`define DMR_CH_HIGH_FIRST 3'h5
// byte enables of a 16-bit forwarded cycle, active low
`define DMR_BE_WORD_N 4'hc

`endif

// >>> shared/dmr_pkg.sv
// types of the distributed dma register redirect block
package dmr_pkg;

	typedef enum logic [2:0] {
		DMR_IDLE = 3'b000,
		DMR_LOCAL = 3'b001,
		DMR_ARB = 3'b010,
		DMR_FWD = 3'b011,
		DMR_CTL = 3'b100,
		DMR_READY = 3'b101
	} dmr_state_t;

	typedef enum logic [1:0] {
		DMR_KIND_ADDRESS = 2'b00,
		DMR_KIND_COUNT = 2'b01,
		DMR_KIND_PAGE = 2'b10,
		DMR_KIND_NONE = 2'b11
	} dmr_kind_t;

	typedef struct packed {
		logic hit;
		logic [2:0] ch;
		dmr_kind_t kind;
	} dmr_dec_t;

	typedef struct packed {
		dmr_state_t state;
		logic [15:0] addr;
		logic write;
		logic [15:0] wdata;
		logic [2:0] ch;
		dmr_kind_t kind;
		logic [15:0] fwd_addr;
		logic [15:0] periph;
		logic [15:0] result;
		logic tgt_done;
		logic tgt_retry;
		logic [15:0] tgt_rdata;
		logic bus_req;
		logic fwd_valid;
		logic ctl_req;
	} dmr_regs_t;

endpackage

// >>> tb/dmr_periph_model.sv
// behavioural pci peripheral holding the relocated channel registers
`timescale 1ns/10ps
module dmr_periph_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// forwarded cycles from the redirect block
	input wire logic bus_req,
	output logic bus_gnt,
	input wire logic fwd_valid,
	input wire logic fwd_write,
	input wire logic [15:0] fwd_addr,
	input wire logic [15:0] fwd_wdata,
	output logic fwd_done,
	output logic [15:0] fwd_rdata,
	// adds wait states
	input wire logic slow
);
	logic [15:0] mem [0:65535];
	logic [1:0] wait_cnt;
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_gnt <= 1'b0;
			fwd_done <= 1'b0;
			fwd_rdata <= 16'h0000;
			wait_cnt <= 2'h0;
		end else begin
			bus_gnt <= bus_req && !bus_gnt;
			fwd_done <= 1'b0;
			// data lines are released outside the answer, so never leave the last value
			fwd_rdata <= ~fwd_rdata;
			if (fwd_valid && !fwd_done) begin
				if (slow && wait_cnt != 2'h3) begin
					wait_cnt <= wait_cnt + 2'h1;
				end else begin
					wait_cnt <= 2'h0;
					fwd_done <= 1'b1;
					// blocks are programmed at aligned places; decode is the full address
					if (fwd_write) begin
						mem[fwd_addr] <= fwd_wdata;
					end else begin
						fwd_rdata <= mem[fwd_addr];
					end
				end
			end
		end
	end
endmodule

// >>> tb/distributed_dma_register_redirect_bench.sv
// self-checking bench of the distributed dma register redirect
`timescale 1ns/10ps
`include "dmr_regs.svh"
module distributed_dma_register_redirect_bench;
	logic ref_clk = 1'b0;
	logic reset_n, alt_access, tgt_req, tgt_write, bus_gnt, fwd_done, slow;
	logic ctl_done = 1'b0;
	logic tgt_done, tgt_retry, bus_req, fwd_valid, fwd_write, ctl_req, ctl_write;
	logic [15:0] ptr_low_group, ptr_high_group, tgt_addr, tgt_wdata, tgt_rdata;
	logic [15:0] fwd_addr, fwd_wdata, fwd_rdata, ctl_addr, ctl_wdata;
	logic [15:0] ctl_rdata = 16'h0000;
	logic [7:0] dist_chan_en;
	logic [3:0] fwd_byte_en_n, last_be;
	logic [15:0] last_fa, last_wd, ctl_wd_last, rnd = 16'h0015;
	logic last_fw;
	int failures = 0, compares = 0, cycles = 0, fwd_cnt = 0, ctl_wr_cnt = 0;

	dmr_redirect dut (.ref_clk, .reset_n, .dist_chan_en, .ptr_low_group, .ptr_high_group, .alt_access,
		.tgt_req, .tgt_write, .tgt_addr, .tgt_wdata, .tgt_done, .tgt_retry, .tgt_rdata, .bus_req, .bus_gnt,
		.fwd_valid, .fwd_write, .fwd_addr, .fwd_wdata, .fwd_byte_en_n, .fwd_done, .fwd_rdata, .ctl_req,
		.ctl_write, .ctl_addr, .ctl_wdata, .ctl_done, .ctl_rdata);
	dmr_periph_model periph (.ref_clk, .reset_n, .bus_req, .bus_gnt, .fwd_valid, .fwd_write, .fwd_addr,
		.fwd_wdata, .fwd_done, .fwd_rdata, .slow);

	always #5 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [15:0] reg_a(logic [2:0] ch, logic [1:0] k);
		logic [15:0] pg [8];
		pg = '{16'h0087, 16'h0083, 16'h0081, 16'h0082, 16'h0000, 16'h008b, 16'h0089, 16'h008a};
		if (k == 2'h2) return pg[ch];
		return ch[2] ? 16'h00c4 + 16'(ch - 3'h5) * 16'h0004 + 16'(k) * 16'h0002 : 16'(ch) * 16'h0002 + 16'(k);
	endfunction

	function automatic logic [15:0] exp_fa(logic [2:0] ch, logic [1:0] k);
		logic [15:0] p;
		p = ch[2] ? ptr_high_group : ptr_low_group;
		return {p[15:6], ch[2] ? ch[1:0] - 2'h1 : ch[1:0],
			k == 2'h0 ? `DMR_IDX_ADDRESS : (k == 2'h1 ? `DMR_IDX_WORD_COUNT : `DMR_IDX_PAGE)};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		if (failures == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// internal controller answers one cycle after each request
	always @(negedge ref_clk) begin
		if (ctl_req === 1'b1 && ctl_done !== 1'b1) begin
			ctl_done = 1'b1;
			ctl_rdata = ctl_addr ^ 16'h5a3c;
			if (ctl_write === 1'b1) begin
				ctl_wr_cnt++;
				ctl_wd_last = ctl_wdata;
			end
		end else begin
			ctl_done = 1'b0;
			ctl_rdata = ~ctl_rdata;
		end
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (fwd_valid === 1'b1 && fwd_done === 1'b1) begin
			fwd_cnt++;
			last_fa = fwd_addr;
			last_be = fwd_byte_en_n;
			last_fw = fwd_write;
			last_wd = fwd_wdata;
		end
		if (cycles == 30000) begin
			failures++;
			final_report();
		end
	end

	task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d, output logic ok,
		output logic [15:0] rd);
		int n;
		@(negedge ref_clk);
		tgt_req = 1'b1;
		tgt_write = wr;
		tgt_addr = a;
		tgt_wdata = d;
		@(negedge ref_clk);
		tgt_req = 1'b0;
		n = 0;
		while (tgt_done !== 1'b1 && tgt_retry !== 1'b1 && n < 60) begin
			@(negedge ref_clk);
			n++;
		end
		ok = tgt_done === 1'b1;
		rd = tgt_rdata;
		if (n == 60) check("answer", 16'h0000, 16'h0001);
	endtask

	task automatic xfer(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic redir,
		output logic [15:0] rd);
		logic ok;
		int n;
		fwd_cnt = 0;
		ctl_wr_cnt = 0;
		access(wr, a, d, ok, rd);
		check("first answer", {15'h0000, ok}, {15'h0000, !redir});
		if (!ok) begin
			// writes wait for the held result so the foreign cycle meets ready; reads meet the busy phases
			if (wr) repeat (12) @(negedge ref_clk);
			access(!wr, a, d, ok, rd);
			check("other direction", {15'h0000, ok}, 16'h0000);
		end
		n = 0;
		while (!ok && n < 40) begin
			access(wr, a, d, ok, rd);
			n++;
		end
		check("completed", {15'h0000, ok}, 16'h0001);
	endtask

	task automatic fwd_op(input logic wr, input logic [2:0] ch, input logic [1:0] k, input logic [15:0] d);
		logic [15:0] a, rd;
		a = reg_a(ch, k);
		xfer(wr, a, d, 1'b1, rd);
		check("fwd count", 16'(fwd_cnt), 16'h0001);
		check("fwd addr", last_fa, exp_fa(ch, k));
		check("fwd width", {12'h000, last_be}, 16'h000c);
		check("fwd dir", {15'h0000, last_fw}, {15'h0000, wr});
		if (wr) begin
			check("fwd data", last_wd, d);
			check("ctl writes", 16'(ctl_wr_cnt), {15'h0000, k == 2'h2});
			if (k == 2'h2) check("ctl data", ctl_wd_last, d);
		end else begin
			check("read data", rd, k == 2'h2 ? {a[15:8] ^ 8'h5a, d[7:0]} : d);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [15:0] wd [3];
		logic [15:0] rd;
		reset_n = 1'b0;
		{alt_access, tgt_req, tgt_write, slow} = 4'h0;
		{tgt_addr, tgt_wdata} = 32'h0;
		dist_chan_en = 8'hff;
		ptr_low_group = 16'h1240;
		ptr_high_group = 16'h3c80;
		repeat (16) @(negedge ref_clk);
		check("reset outputs", {7'h00, tgt_done, tgt_retry, bus_req, fwd_valid, ctl_req, fwd_byte_en_n}, 16'h000c);
		reset_n = 1'b1;
		for (int r = 0; r < 3; r++) begin
			rnd = lfsr(rnd);
			ptr_low_group = rnd;
			rnd = lfsr(rnd);
			ptr_high_group = rnd;
			// alternate so both partner timings are met whatever the seed gives
			slow = r[0];
			for (int c = 0; c < 8; c++) begin
				if (c == 4) continue;
				for (int k = 0; k < 3; k++) begin
					rnd = lfsr(rnd);
					wd[k] = rnd;
					fwd_op(1'b1, 3'(c), 2'(k), wd[k]);
				end
				for (int k = 0; k < 3; k++) fwd_op(1'b0, 3'(c), 2'(k), wd[k]);
			end
		end
		// state-save mode keeps everything local, base registers included
		alt_access = 1'b1;
		xfer(1'b0, `DMR_CH1_ADDRESS, 16'h0000, 1'b0, rd);
		check("saved read", rd, `DMR_CH1_ADDRESS ^ 16'h5a3c);
		xfer(1'b1, `DMR_CH1_WORD_COUNT, 16'h7e81, 1'b0, rd);
		check("saved write", ctl_wd_last, 16'h7e81);
		check("no forward", 16'(fwd_cnt), 16'h0000);
		alt_access = 1'b0;
		dist_chan_en = 8'hf7;
		xfer(1'b0, `DMR_CH3_ADDRESS, 16'h0000, 1'b0, rd);
		check("local read", rd, `DMR_CH3_ADDRESS ^ 16'h5a3c);
		xfer(1'b0, 16'h00c0, 16'h0000, 1'b0, rd);
		check("channel four", rd, 16'h00c0 ^ 16'h5a3c);
		final_report();
	end
endmodule
